// ### adcif_pkg.sv
// package: timing constants, frame layout and states for the converter host controller
package adcif_pkg;
   // ==========================================
   // clock and timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int CONV_TIME_FAST_NS = 1470;
   localparam int CONV_TIME_SLOW_NS = 1600;
   localparam int ACQ_TIME_FAST_NS = 200;
   localparam int ACQ_TIME_SLOW_NS = 400;
   localparam int EOC_PULSE_NS = 100;
   localparam int TRIG_LOW_NS = 40;
   localparam int SCLK_HALF_CYCLES = 4;
   // least times round up to whole cycles
   localparam int ACQ_FAST_CYC = (ACQ_TIME_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_SLOW_CYC = (ACQ_TIME_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRIG_LOW_CYC = (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest wait for end of conversion: slow conversion plus margin
   localparam int EOC_WAIT_CYC = (2 * CONV_TIME_SLOW_NS) / CLK_PERIOD_NS;
   localparam int RD_PULSE_CYC = 8;
   // ==========================================
   // frame layout
   localparam int RESULT_W = 12;
   localparam int FRAME_BITS = 16;
   localparam int LEAD_ZEROS = 4;
   localparam int CNT_W = 9;
   // ==========================================
   // controller states, gray along the usual path from IDLE to ACQ
   typedef enum logic [2:0] {
      ADCIF_IDLE = 3'b000,
      ADCIF_TRIG = 3'b001,
      ADCIF_CONV = 3'b011,
      ADCIF_READ = 3'b010,
      ADCIF_DONE = 3'b110,
      ADCIF_ACQ  = 3'b111
   } adcif_state_t;
endpackage

// ### adcif_host.sv
// module: host controller that starts conversions and reads results from the converter
`timescale 1ns/1ns
module adcif_host
   import adcif_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic parallel_mode,
   output logic sample_trigger_n,
   input wire logic eoc_n,
   output logic cs_n,
   output logic rd_n,
   input wire logic [RESULT_W-1:0] data_in,
   output logic data3_or_frame_sync,
   output logic data3_oe,
   output logic sclk,
   input wire logic serial_out,
   output logic [RESULT_W-1:0] result,
   output logic result_valid,
   output logic busy,
   output logic timeout
);
   // elaboration checks: the phase counter is three bits wide, and a sampled bit
   // must pass the synchroniser within one half period of the serial clock
   if (SCLK_HALF_CYCLES < 3 || SCLK_HALF_CYCLES > 8) begin : g_sclk_check
      $error("serial clock half period outside 3 to 8 cycles");
   end
   // the end-of-conversion wait must fit the shared counter
   if (EOC_WAIT_CYC >= (1 << CNT_W)) begin : g_cnt_check
      $error("end-of-conversion wait does not fit the counter");
   end
   // ==========================================
   // pin synchronisers; first stage feeds only the second
   logic eoc_s1_reg, eoc_s2_reg, eoc_s3_reg;
   logic sdo_s1_reg, sdo_s2_reg;
   logic [RESULT_W-1:0] din_s1_reg, din_s2_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         eoc_s1_reg <= 1'b1;
         eoc_s2_reg <= 1'b1;
         eoc_s3_reg <= 1'b1;
         sdo_s1_reg <= 1'b0;
         sdo_s2_reg <= 1'b0;
         din_s1_reg <= '0;
         din_s2_reg <= '0;
      end else begin
         eoc_s1_reg <= eoc_n;
         eoc_s2_reg <= eoc_s1_reg;
         eoc_s3_reg <= eoc_s2_reg;
         sdo_s1_reg <= serial_out;
         sdo_s2_reg <= sdo_s1_reg;
         din_s1_reg <= data_in;
         din_s2_reg <= din_s1_reg;
      end
   end
   // falling edge of end-of-conversion, seen after the synchroniser
   logic eoc_fall;
   assign eoc_fall = eoc_s3_reg & ~eoc_s2_reg;
   // ==========================================
   // state registers
   adcif_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [4:0] bit_reg, bit_next;
   logic [2:0] ph_reg, ph_next;
   logic mode_reg, mode_next;
   logic trig_reg, trig_next;
   logic cs_reg, cs_next, rd_reg, rd_next;
   logic fs_reg, fs_next, fsoe_reg, fsoe_next, sclk_reg, sclk_next;
   logic [FRAME_BITS-1:0] sh_reg, sh_next;
   logic [RESULT_W-1:0] res_reg, res_next;
   logic val_reg, val_next, busy_reg, busy_next, to_reg, to_next;
   // acquisition wait for the grade in use
   localparam logic [CNT_W-1:0] ACQ_CYC =
      FAST_GRADE ? CNT_W'(ACQ_FAST_CYC) : CNT_W'(ACQ_SLOW_CYC);
   // ==========================================
   // next-state logic
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      ph_next = ph_reg;
      mode_next = mode_reg;
      trig_next = trig_reg;
      cs_next = cs_reg;
      rd_next = rd_reg;
      fs_next = fs_reg;
      fsoe_next = fsoe_reg;
      sclk_next = sclk_reg;
      sh_next = sh_reg;
      res_next = res_reg;
      val_next = 1'b0;
      busy_next = busy_reg;
      to_next = to_reg;
      case (state_reg)
         ADCIF_IDLE: begin
            // strap caught here, after reset release, per conversion
            mode_next = parallel_mode;
            fsoe_next = ~parallel_mode;
            fs_next = 1'b1;
            if (start) begin
               state_next = ADCIF_TRIG;
               trig_next = 1'b0;
               cnt_next = '0;
               busy_next = 1'b1;
               to_next = 1'b0;
            end
         end
         ADCIF_TRIG: begin
            // hold the trigger low, then release: the rise starts conversion
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(TRIG_LOW_CYC - 1)) begin
               trig_next = 1'b1;
               state_next = ADCIF_CONV;
               cnt_next = '0;
            end
         end
         ADCIF_CONV: begin
            // no serial traffic while converting
            cnt_next = cnt_reg + 1'b1;
            if (eoc_fall) begin
               state_next = ADCIF_READ;
               cnt_next = '0;
               bit_next = '0;
               ph_next = '0;
               if (mode_reg) begin
                  // strobes follow the end pulse, as a tied partner would, but are
                  // pulsed briefly and never parked low
                  cs_next = 1'b0;
                  rd_next = 1'b0;
               end else begin
                  fs_next = 1'b0;
               end
            end else if (cnt_reg == CNT_W'(EOC_WAIT_CYC)) begin
               // converter never answered; give up rather than hang
               to_next = 1'b1;
               state_next = ADCIF_ACQ;
               cnt_next = '0;
            end
         end
         ADCIF_READ: begin
            if (mode_reg) begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg == CNT_W'(RD_PULSE_CYC - 1)) begin
                  // sample just before raising the strobes
                  res_next = din_s2_reg;
                  cs_next = 1'b1;
                  rd_next = 1'b1;
                  state_next = ADCIF_DONE;
               end
            end else begin
               // frame sync went low a full half period before the first rise
               ph_next = ph_reg + 1'b1;
               if (ph_reg == 3'(SCLK_HALF_CYCLES - 1)) begin
                  ph_next = '0;
                  if (!sclk_reg) begin
                     sclk_next = 1'b1;
                  end else begin
                     // sample on falling edge; resync delay stays inside half period
                     sclk_next = 1'b0;
                     sh_next = {sh_reg[FRAME_BITS-2:0], sdo_s2_reg};
                     bit_next = bit_reg + 1'b1;
                     if (bit_reg == 5'(FRAME_BITS - 1)) begin
                        // rising sync releases the data line
                        fs_next = 1'b1;
                        state_next = ADCIF_DONE;
                     end
                  end
               end
            end
         end
         ADCIF_DONE: begin
            // raw code handed over; sign handling is the user's per grade
            if (!mode_reg) begin
               res_next = sh_reg[RESULT_W-1:0];
            end
            val_next = 1'b1;
            state_next = ADCIF_ACQ;
            cnt_next = '0;
         end
         ADCIF_ACQ: begin
            // acquisition and read-to-start clearance before a new start
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg >= ACQ_CYC) begin
               busy_next = 1'b0;
               state_next = ADCIF_IDLE;
            end
         end
         default: begin
            state_next = ADCIF_IDLE;
         end
      endcase
   end
   // ==========================================
   // registers
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= ADCIF_IDLE;
         cnt_reg <= '0;
         bit_reg <= '0;
         ph_reg <= '0;
         mode_reg <= 1'b1;
         trig_reg <= 1'b1;
         cs_reg <= 1'b1;
         rd_reg <= 1'b1;
         fs_reg <= 1'b1;
         fsoe_reg <= 1'b0;
         sclk_reg <= 1'b0;
         sh_reg <= '0;
         res_reg <= '0;
         val_reg <= 1'b0;
         busy_reg <= 1'b0;
         to_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         ph_reg <= ph_next;
         mode_reg <= mode_next;
         trig_reg <= trig_next;
         cs_reg <= cs_next;
         rd_reg <= rd_next;
         fs_reg <= fs_next;
         fsoe_reg <= fsoe_next;
         sclk_reg <= sclk_next;
         sh_reg <= sh_next;
         res_reg <= res_next;
         val_reg <= val_next;
         busy_reg <= busy_next;
         to_reg <= to_next;
      end
   end
   assign sample_trigger_n = trig_reg;
   assign cs_n = cs_reg;
   assign rd_n = rd_reg;
   assign data3_or_frame_sync = fs_reg;
   assign data3_oe = fsoe_reg;
   assign sclk = sclk_reg;
   assign result = res_reg;
   assign result_valid = val_reg;
   assign busy = busy_reg;
   assign timeout = to_reg;
endmodule

// ### adcif_host_asserts.sv
// checker: port timing of the converter host controller
`timescale 1ns/1ns
module adcif_host_asserts
   import adcif_pkg::*;
#(parameter bit FAST_GRADE = 1'b1) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic sample_trigger_n,
   input wire logic eoc_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic data3_or_frame_sync,
   input wire logic data3_oe,
   input wire logic sclk,
   input wire logic result_valid,
   input wire logic busy
);
   // quiet spell owed before the sampler may hold again
   localparam int MIN_GAP = FAST_GRADE ? ACQ_FAST_CYC : ACQ_SLOW_CYC;
   logic [7:0] gap_reg, gap_next; // cycles since read or eoc activity, saturates
   logic [4:0] rise_reg, rise_next; // sclk rises seen in this frame
   logic sclk_reg, sclk_next; // sclk one cycle back, for edge finding
   // ==========================================
   // helper counters
   always_comb begin
      sclk_next = sclk;
      gap_next = (gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01;
      if (!rd_n || !data3_or_frame_sync || !eoc_n) begin
         gap_next = 8'h00;
      end
      rise_next = data3_or_frame_sync ? 5'h00 : rise_reg + {4'h0, sclk & ~sclk_reg};
   end
   // saturated at reset so the first start is legal
   always_ff @(posedge clk) begin
      if (reset) begin
         gap_reg <= 8'hFF;
         rise_reg <= 5'h00;
         sclk_reg <= 1'b0;
      end else begin
         gap_reg <= gap_next;
         rise_reg <= rise_next;
         sclk_reg <= sclk_next;
      end
   end
   // ==========================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence trig_pulse_s;
      (!sample_trigger_n) [*5] ##1 sample_trigger_n;
   endsequence
   sequence strobe_s;
      (!cs_n && !rd_n) [*8] ##1 (cs_n && rd_n);
   endsequence
   a_start_taken: assert property (start && !busy |=> busy ##[0:1] !sample_trigger_n)
      else $error("start not taken");
   a_trig_width: assert property ($fell(sample_trigger_n) |-> trig_pulse_s)
      else $error("trigger pulse width wrong");
   a_strobe_pair: assert property ($fell(rd_n) |-> strobe_s)
      else $error("read strobe pair wrong");
   a_read_after_eoc: assert property ($fell(eoc_n) && busy |->
      ##[2:6] (!rd_n || !data3_or_frame_sync))
      else $error("no read after end of conversion");
   a_read_gap: assert property ($rose(sample_trigger_n) |-> gap_reg >= MIN_GAP)
      else $error("trigger too soon after read");
   a_frame_count: assert property ($rose(data3_or_frame_sync) |-> rise_reg == 5'h10)
      else $error("frame clock count wrong");
   a_sclk_idle: assert property (data3_or_frame_sync |-> !sclk)
      else $error("serial clock outside frame");
   a_mode_split: assert property (data3_oe |-> cs_n && rd_n)
      else $error("strobes in serial mode");
   a_sync_driven: assert property (!data3_or_frame_sync |-> data3_oe)
      else $error("frame sync not driven");
   a_valid_pulse: assert property (result_valid |=> !result_valid)
      else $error("valid longer than a cycle");
endmodule
bind adcif_host adcif_host_asserts #(.FAST_GRADE(FAST_GRADE)) chk (.clk, .reset, .start,
   .sample_trigger_n, .eoc_n, .cs_n, .rd_n, .data3_or_frame_sync, .data3_oe, .sclk,
   .result_valid, .busy);

// ### adcif_dev_model.sv
// partner: behavioural converter with parallel and serial result ports
`timescale 1ns/1ns
module adcif_dev_model
   import adcif_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b1
) (
   input wire logic clk,
   input wire logic sample_trigger_n,
   input wire logic eoc_enable,
   input wire logic [RESULT_W-1:0] code,
   input wire logic parallel_mode,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic frame_sync_n,
   input wire logic sclk,
   output logic eoc_n,
   output logic [RESULT_W-1:0] data_out,
   output logic serial_out
);
   logic [RESULT_W-1:0] out_reg = 12'h000; // output register, kept to next result
   logic [FRAME_BITS-1:0] frame_reg = 16'h0000;
   logic bit_reg = 1'b0;
   logic shift_on = 1'b0; // serial line driven
   logic fs_seen = 1'b1; // frame sync level at the last event
   logic eoc_reg = 1'b1; // end-of-conversion level, idles high
   int bit_cnt = 0;
   // conversion: hold on trigger rise, result then low eoc pulse
   always @(posedge sample_trigger_n) begin
      if (eoc_enable) begin
         #(FAST_GRADE ? CONV_TIME_FAST_NS : CONV_TIME_SLOW_NS);
         out_reg = code;
         eoc_reg = 1'b0;
         #(EOC_PULSE_NS);
         eoc_reg = 1'b1;
      end
   end
   assign eoc_n = eoc_reg;
   // released bus shows the inverse, so an early or late sample is caught
   assign data_out = (parallel_mode && !cs_n && !rd_n) ? out_reg : ~out_reg;
   // serial frame: four zeros then the code, one bit per rising clock
   always @(posedge sclk or frame_sync_n) begin
      if (frame_sync_n !== fs_seen) begin
         // any sync change reloads the frame; a rising sync releases the line
         fs_seen = frame_sync_n;
         frame_reg = {4'h0, out_reg};
         bit_cnt = 0;
         shift_on = 1'b0;
      end else begin
         shift_on = !parallel_mode && !frame_sync_n && bit_cnt < FRAME_BITS;
         if (shift_on) begin
            bit_reg = frame_reg[FRAME_BITS-1-bit_cnt];
            bit_cnt++;
         end
      end
   end
   assign serial_out = shift_on ? bit_reg : ~bit_reg;
endmodule

// ### adcif_host_bench.sv
// testbench: host controller against a behavioural converter
`timescale 1ns/1ns
module adcif_host_bench
   import adcif_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0;
   logic parallel_mode = 1'b1;
   logic eoc_enable = 1'b1;
   logic [RESULT_W-1:0] code = 12'h000;
   logic sample_trigger_n, eoc_n, cs_n, rd_n, fs_n, oe, sclk, serial_out;
   logic result_valid, busy, timeout;
   logic [RESULT_W-1:0] result, dev_data, data_in;
   logic [RESULT_W-1:0] edge_codes [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
   int err_count = 0;
   int num_checks = 0;
   int seed = 33377;
   int exp_q[$]; // codes the host still owes
   always #4 clk = ~clk;
   // pin 3 carries frame sync in serial mode
   assign data_in = {dev_data[11:4], oe ? fs_n : dev_data[3], dev_data[2:0]};
   adcif_host #(.FAST_GRADE(1'b1)) uut (.clk, .reset, .start, .parallel_mode,
      .sample_trigger_n, .eoc_n, .cs_n, .rd_n, .data_in, .data3_or_frame_sync(fs_n),
      .data3_oe(oe), .sclk, .serial_out, .result, .result_valid, .busy, .timeout);
   adcif_dev_model #(.FAST_GRADE(1'b1)) dev (.clk, .sample_trigger_n, .eoc_enable, .code,
      .parallel_mode, .cs_n, .rd_n, .frame_sync_n(oe ? fs_n : 1'b1), .sclk, .eoc_n,
      .data_out(dev_data), .serial_out);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (err_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // each result is matched against the oldest owed code, mid-cycle when settled
   always @(negedge clk) begin
      if (result_valid === 1'b1) begin
         check("result", 32'(result), exp_q.size() > 0 ? exp_q.pop_front() : -1);
      end
   end
   // one conversion; a second start while busy must be ignored
   task automatic convert(input logic mode, input logic [11:0] c, input logic en,
      input logic twice);
      int n;
      parallel_mode <= mode;
      code <= c;
      eoc_enable <= en;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      if (en) exp_q.push_back(int'(c));
      repeat (60) @(posedge clk);
      start <= twice;
      @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < 1000 && busy !== 1'b0; n++) @(posedge clk);
      @(posedge clk);
      check("idle", {n < 1000, busy, timeout}, {2'b10, !en});
      check("owed", exp_q.size(), 0);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check("reset", {sample_trigger_n, cs_n, rd_n, fs_n, oe, sclk, result_valid, busy,
         timeout, result}, 32'h001E0000);
      for (int i = 0; i < 12; i++) begin
         convert(i[0], i < 4 ? edge_codes[i] : 12'($random(seed)), 1'b1, i == 2 || i == 5);
      end
      convert(1'b1, 12'hABC, 1'b0, 1'b0);
      convert(1'b0, 12'($random(seed)), 1'b1, 1'b0);
      finish_test();
   end
   // watchdog: fourteen conversions need well under 20000 cycles
   initial begin
      #(20000 * CLK_PERIOD_NS);
      err_count++;
      finish_test();
   end
endmodule
